// >>> src/bbi_pkg.sv
// Summary of operation
// - every off-board memory or I/O access runs as one byte transfer
// - each backplane read or write takes four bus clocks without waits
// - one internal wait state lets slow peripherals request more waits
// - memory addresses missing every on-board region go to the backplane
// - I/O addresses missing every on-board decode go to the backplane
// - off-board memory address is 24 bits, top four bits zero
// - off-board I/O drives all sixteen address bits
// - IOEXP driven low for I/O addresses FC00h to FFFFh; here only FC00h to FFEFh, as FFF0h up stays on-board
// - IOEXP kept high for every I/O address below FC00h; here only off-board ones, as FA00h to FBFFh stays on-board
// - MEMEX passively high unless the ground strap is fitted
// - finish current instruction, then assert bus acknowledge
// - address buffers turn inward together with bus acknowledge
`default_nettype none
package bbi_pkg;
  localparam int unsigned CPU_AW    = 20;
  localparam int unsigned STD_AW    = 24;
  localparam int unsigned IO_AW     = 16;
  localparam int unsigned DW        = 8;
  localparam logic [15:0] IOEXP_LO  = 16'hFC00;
  localparam logic [3:0]  A_HI_ZERO = 4'h0;
  // memory regions decoded on-board: below A0000h and E0000h up
  localparam logic [19:0] MEM_LO_END = 20'hA0000;
  localparam logic [19:0] MEM_HI_BEG = 20'hE0000;
  // on-board I/O windows
  localparam logic [15:0] IO_OB0_BEG = 16'hFA00;
  localparam logic [15:0] IO_OB0_END = 16'hFBFF;
  localparam logic [15:0] IO_OB1_BEG = 16'hFFF0;
  localparam int unsigned XFER_CYC  = 4;
  localparam logic [1:0]  LAST_T    = 2'(XFER_CYC - 1);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_T1   = 3'b001,
    ST_T2   = 3'b011,
    ST_T3   = 3'b010,
    ST_T4   = 3'b110,
    ST_GRNT = 3'b100
  } bbi_state_t;
endpackage : bbi_pkg
`default_nettype wire

// >>> src/bbi_decode.sv
`timescale 1ns/1ps
`default_nettype none
module bbi_decode
  import bbi_pkg::*;
(
  input  wire logic [19:0] addr_in,
  input  wire logic        is_io_in,
  output logic             offboard_out
);
  logic [15:0] io_a;
  always_comb begin
    io_a = addr_in[15:0];
    if (is_io_in) begin
      offboard_out = !((io_a >= IO_OB0_BEG && io_a <= IO_OB0_END) ||
                       (io_a >= IO_OB1_BEG));
    end else begin
      offboard_out = (addr_in >= MEM_LO_END) &&
                     (addr_in < MEM_HI_BEG);
    end
  end
endmodule : bbi_decode
`default_nettype wire

// >>> src/bbi_top.sv
`timescale 1ns/1ps
`default_nettype none
module bbi_top
  import bbi_pkg::*;
(
  // clock and reset
  input  wire logic                CORE_CLK_IN,
  input  wire logic                SYS_RST_IN,
  // processor side
  input  wire logic                CPU_REQ_IN,
  input  wire logic                CPU_IO_IN,
  input  wire logic                CPU_WR_IN,
  input  wire logic [19:0]         CPU_ADDR_IN,
  input  wire logic [7:0]          CPU_WDATA_IN,
  input  wire logic                CPU_INSTR_END_IN,
  output logic                     CPU_OFFBOARD_OUT,
  output logic                     CPU_READY_OUT,
  output logic [7:0]               CPU_RDATA_OUT,
  output logic                     CPU_HOLD_OUT,
  // backplane
  output logic [23:0]              STD_ADDR_OUT,
  output logic [7:0]               STD_DATA_OUT,
  output logic                     STD_DATA_OE_OUT,
  input  wire logic [7:0]          STD_DATA_IN,
  output logic                     STD_MEMRQ_N_OUT,
  output logic                     STD_IORQ_N_OUT,
  output logic                     STD_RD_N_OUT,
  output logic                     STD_WR_N_OUT,
  input  wire logic                STD_WAIT_N_IN,
  output logic                     STD_IOEXP_OUT,
  output logic                     STD_IOEXP_OE_OUT,
  output logic                     STD_MEMEX_OUT,
  output logic                     STD_MEMEX_OE_OUT,
  input  wire logic                BYTE_HIGH_GROUND_STRAP_IN,
  input  wire logic                STD_BUSRQ_N_IN,
  output logic                     STD_BUSAK_N_OUT,
  output logic                     ADDR_BUF_INWARD_OUT
);
  import bbi_pkg::*;

  bbi_state_t  st_q, st_d;
  logic [23:0] addr_q, addr_d;
  logic [7:0]  wdat_q, wdat_d, rdat_q, rdat_d;
  logic        io_q, io_d, wr_q, wr_d, strap_q, strap_d;
  logic        offb;

  bbi_decode u_dec (
    .addr_in      (CPU_ADDR_IN),
    .is_io_in     (CPU_IO_IN),
    .offboard_out (offb)
  );

  always_comb begin
    st_d    = st_q;
    addr_d  = addr_q;
    wdat_d  = wdat_q;
    rdat_d  = rdat_q;
    io_d    = io_q;
    wr_d    = wr_q;
    strap_d = BYTE_HIGH_GROUND_STRAP_IN;
    unique case (st_q)
      ST_IDLE: begin
        if (!STD_BUSRQ_N_IN && CPU_INSTR_END_IN) begin
          st_d = ST_GRNT;
        end else if (CPU_REQ_IN && offb) begin
          st_d   = ST_T1;
          io_d   = CPU_IO_IN;
          wr_d   = CPU_WR_IN;
          wdat_d = CPU_WDATA_IN;
          if (CPU_IO_IN) begin
            addr_d = {8'h00, CPU_ADDR_IN[15:0]};
          end else begin
            addr_d = {A_HI_ZERO, CPU_ADDR_IN};
          end
        end
      end
      ST_T1: st_d = ST_T2;
      // the internal wait state sits here; a slow slave holds it by WAIT
      ST_T2: if (STD_WAIT_N_IN) st_d = ST_T3;
      ST_T3: begin
        st_d = ST_T4;
        if (!wr_q) rdat_d = STD_DATA_IN;
      end
      ST_T4: st_d = ST_IDLE;
      // an external master must keep standard cycle timing meanwhile
      ST_GRNT: if (STD_BUSRQ_N_IN) st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      st_q    <= ST_IDLE;
      addr_q  <= 24'h000000;
      wdat_q  <= 8'h00;
      rdat_q  <= 8'h00;
      io_q    <= 1'b0;
      wr_q    <= 1'b0;
      strap_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      addr_q  <= addr_d;
      wdat_q  <= wdat_d;
      rdat_q  <= rdat_d;
      io_q    <= io_d;
      wr_q    <= wr_d;
      strap_q <= strap_d;
    end
  end

  logic act, grant;
  assign act   = (st_q != ST_IDLE) && (st_q != ST_GRNT);
  assign grant = (st_q == ST_GRNT);

  assign CPU_OFFBOARD_OUT = offb;
  assign CPU_READY_OUT    = (st_q == ST_T4);
  assign CPU_RDATA_OUT    = rdat_q;
  assign CPU_HOLD_OUT     = grant;
  assign STD_ADDR_OUT     = addr_q;
  assign STD_DATA_OUT     = wdat_q;
  assign STD_DATA_OE_OUT  = act && wr_q;
  assign STD_MEMRQ_N_OUT  = !(act && !io_q);
  assign STD_IORQ_N_OUT   = !(act && io_q);
  assign STD_RD_N_OUT     = !(act && !wr_q && st_q != ST_T1);
  assign STD_WR_N_OUT     = !(act && wr_q && st_q != ST_T1);
  // ioexp driven only while we master an I/O cycle
  assign STD_IOEXP_OUT    = !(addr_q[15:0] >= IOEXP_LO);
  assign STD_IOEXP_OE_OUT = act && io_q;
  // memex: never actively high, pull-up does that; strap grounds it
  assign STD_MEMEX_OUT    = 1'b0;
  assign STD_MEMEX_OE_OUT = strap_q;
  assign STD_BUSAK_N_OUT     = !grant;
  assign ADDR_BUF_INWARD_OUT = grant;

  // bus clocks of the running transfer; wait cycles are not counted, so
  // a stretched cycle still has to land on the same count at T4
  logic [1:0] cyc_cnt_q, cyc_cnt_d;

  always_comb begin
    cyc_cnt_d = cyc_cnt_q;
    if (!act) begin
      cyc_cnt_d = 2'h0;
    end else if (!(st_q == ST_T2 && !STD_WAIT_N_IN)) begin
      cyc_cnt_d = cyc_cnt_q + 2'h1;
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      cyc_cnt_q <= 2'h0;
    end else begin
      cyc_cnt_q <= cyc_cnt_d;
    end
  end

  sequence s_start;
    st_q == ST_IDLE && CPU_REQ_IN && offb && STD_BUSRQ_N_IN;
  endsequence

  sequence s_bus_claim;
    st_q == ST_IDLE && !STD_BUSRQ_N_IN && CPU_INSTR_END_IN;
  endsequence

  a_xfer_four_clk: assert property (@(posedge CORE_CLK_IN)
    disable iff (SYS_RST_IN)
    s_start ##1 (st_q == ST_T1) ##1 STD_WAIT_N_IN |=> ##1 CPU_READY_OUT)
    else $error("transfer not four clocks");
  a_wait_holds: assert property (@(posedge CORE_CLK_IN)
    disable iff (SYS_RST_IN)
    (st_q == ST_T2 && !STD_WAIT_N_IN) |=> st_q == ST_T2)
    else $error("wait not honoured");
  a_mem_hi_zero: assert property (@(posedge CORE_CLK_IN)
    disable iff (SYS_RST_IN)
    (act && !io_q) |-> STD_ADDR_OUT[23:20] == A_HI_ZERO)
    else $error("upper address not zero");
  a_io_addr_full: assert property (@(posedge CORE_CLK_IN)
    disable iff (SYS_RST_IN)
    s_start ##0 CPU_IO_IN |=> STD_ADDR_OUT[15:0] == $past(CPU_ADDR_IN[15:0]))
    else $error("io address truncated");
  a_ioexp_low: assert property (@(posedge CORE_CLK_IN)
    disable iff (SYS_RST_IN)
    (STD_IOEXP_OE_OUT && addr_q[15:0] >= IOEXP_LO) |-> !STD_IOEXP_OUT)
    else $error("ioexp not low");
  a_ioexp_high: assert property (@(posedge CORE_CLK_IN)
    disable iff (SYS_RST_IN)
    (STD_IOEXP_OE_OUT && addr_q[15:0] < IOEXP_LO) |-> STD_IOEXP_OUT)
    else $error("ioexp not high");
  a_memex_passive: assert property (@(posedge CORE_CLK_IN)
    disable iff (SYS_RST_IN)
    STD_MEMEX_OE_OUT |-> (!STD_MEMEX_OUT && $past(BYTE_HIGH_GROUND_STRAP_IN)))
    else $error("memex driven without strap");
  a_grant_wait: assert property (@(posedge CORE_CLK_IN)
    disable iff (SYS_RST_IN)
    $fell(STD_BUSAK_N_OUT) |-> $past(CPU_INSTR_END_IN) && !act)
    else $error("grant before instruction end");
  a_buf_inward: assert property (@(posedge CORE_CLK_IN)
    disable iff (SYS_RST_IN)
    ADDR_BUF_INWARD_OUT == !STD_BUSAK_N_OUT)
    else $error("buffer direction mismatch");
  a_release: assert property (@(posedge CORE_CLK_IN)
    disable iff (SYS_RST_IN)
    (grant && STD_BUSRQ_N_IN) |=> STD_BUSAK_N_OUT && !ADDR_BUF_INWARD_OUT)
    else $error("bus not released");
  a_byte_xfer: assert property (@(posedge CORE_CLK_IN)
    disable iff (SYS_RST_IN)
    CPU_READY_OUT |-> (cyc_cnt_q == LAST_T) ##1 (!act))
    else $error("transfer length or byte count wrong");
  a_ready_pulse: assert property (@(posedge CORE_CLK_IN)
    disable iff (SYS_RST_IN)
    CPU_READY_OUT |=> !CPU_READY_OUT)
    else $error("ready longer than one clock");

  a_onboard_quiet: assert property (@(posedge CORE_CLK_IN)
    disable iff (SYS_RST_IN)
    (st_q == ST_IDLE && CPU_REQ_IN && !offb) |=> !act)
    else $error("on-board access went to the backplane");
  a_dma_priority: assert property (@(posedge CORE_CLK_IN)
    disable iff (SYS_RST_IN)
    s_bus_claim |=> grant && ADDR_BUF_INWARD_OUT)
    else $error("bus request not granted");
  a_idle_quiet: assert property (@(posedge CORE_CLK_IN)
    disable iff (SYS_RST_IN)
    !act |-> (STD_MEMRQ_N_OUT && STD_IORQ_N_OUT && STD_RD_N_OUT &&
              STD_WR_N_OUT && !STD_DATA_OE_OUT && !STD_IOEXP_OE_OUT))
    else $error("backplane driven while not mastering");
endmodule : bbi_top
`default_nettype wire

// >>> tb/bbi_std_peer.sv
`timescale 1ns/1ps
`default_nettype none
module bbi_std_peer (
  input  wire logic        clk_in,
  input  wire logic [23:0] addr_in,
  input  wire logic        rd_n_in,
  input  wire logic        wr_n_in,
  input  wire logic [1:0]  waits_in,
  input  wire logic        dma_go_in,
  output logic [7:0]       data_out,
  output logic             wait_n_out,
  output logic             busrq_n_out
);
  logic [1:0] held_q = 2'h0;
  logic [7:0] last_q = 8'h00;
  logic       strobe;
  assign strobe = !rd_n_in || !wr_n_in;
  // slow board: hold wait low for the first waits_in strobe cycles
  assign wait_n_out = !(strobe && held_q < waits_in);
  // released bus never repeats its last value
  assign data_out = !rd_n_in ? (addr_in[7:0] ^ 8'hA5) : ~last_q;
  // the dma master only requests here; its own cycles use no port of ours
  assign busrq_n_out = !dma_go_in;
  always @(posedge clk_in) begin
    held_q <= !strobe ? 2'h0 : held_q + 2'(held_q < waits_in);
    last_q <= data_out;
  end
endmodule : bbi_std_peer
`default_nettype wire

// >>> tb/backplane_bus_interface_test.sv
`timescale 1ns/1ps
`default_nettype none
module backplane_bus_interface_test;
  import bbi_pkg::*;
  logic clk = 0, rst = 1, req = 0, io = 0, wr = 0, iend = 1, strap = 0;
  logic dma = 0, off, rdy, hold, doe, mrq, irq, rdn, wrn, iox, ioxoe;
  logic mx, mxoe, ak, inw, waitn, brq;
  logic [19:0] a = 20'h0;
  logic [7:0]  wd = 8'h0, rdat, sdo, sdi;
  logic [1:0]  wt = 2'h0;
  logic [23:0] sa;
  int mismatches = 0, compares = 0, cyc = 0;
  bbi_top uut (.CORE_CLK_IN(clk), .SYS_RST_IN(rst), .CPU_REQ_IN(req),
    .CPU_IO_IN(io), .CPU_WR_IN(wr), .CPU_ADDR_IN(a), .CPU_WDATA_IN(wd),
    .CPU_INSTR_END_IN(iend), .CPU_OFFBOARD_OUT(off), .CPU_READY_OUT(rdy),
    .CPU_RDATA_OUT(rdat), .CPU_HOLD_OUT(hold), .STD_ADDR_OUT(sa),
    .STD_DATA_OUT(sdo), .STD_DATA_OE_OUT(doe), .STD_DATA_IN(sdi),
    .STD_MEMRQ_N_OUT(mrq), .STD_IORQ_N_OUT(irq), .STD_RD_N_OUT(rdn),
    .STD_WR_N_OUT(wrn), .STD_WAIT_N_IN(waitn), .STD_IOEXP_OUT(iox),
    .STD_IOEXP_OE_OUT(ioxoe), .STD_MEMEX_OUT(mx), .STD_MEMEX_OE_OUT(mxoe),
    .BYTE_HIGH_GROUND_STRAP_IN(strap), .STD_BUSRQ_N_IN(brq),
    .STD_BUSAK_N_OUT(ak), .ADDR_BUF_INWARD_OUT(inw));
  bbi_std_peer peer (.clk_in(clk), .addr_in(sa), .rd_n_in(rdn),
    .wr_n_in(wrn), .waits_in(wt), .dma_go_in(dma), .data_out(sdi),
    .wait_n_out(waitn), .busrq_n_out(brq));
  always #25 clk = ~clk;
  task automatic complete_run;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  function automatic logic offb(input logic i, input logic [19:0] x);
    if (i) return !((x[15:0] >= IO_OB0_BEG && x[15:0] <= IO_OB0_END)
                    || x[15:0] >= IO_OB1_BEG);
    return x >= MEM_LO_END && x < MEM_HI_BEG;
  endfunction : offb
  task automatic step;
    @(posedge clk);
    #5;
  endtask : step
  task automatic xfer(input logic i, input logic w, input logic [19:0] x,
                      input logic [7:0] d, input logic [1:0] n);
    int c;
    c = 0;
    io = i; wr = w; a = x; wd = d; wt = n; req = 1;
    #1 chk(32'(off), 32'(offb(i, x)));
    if (offb(i, x)) begin
      while (!rdy && c < 40) begin
        step();
        c++;
      end
      chk(c, 4 + n);
      // unused upper address lines must read zero for both cycle kinds
      chk({8'h0, sa}, i ? {16'h0, x[15:0]} : {12'h0, x});
      chk({mrq, irq, rdn, wrn}, {i, !i, w, !w});
      if (i) chk({ioxoe, iox}, {1'b1, x[15:0] < IOEXP_LO});
      else chk(ioxoe, 0);
      if (w) chk({doe, sdo}, {1'b1, d});
      else chk({doe, rdat}, {1'b0, x[7:0] ^ 8'hA5});
    end else begin
      repeat (6) begin
        step();
        chk({rdy, mrq, irq}, 3'b011);
      end
    end
    req = 0;
    step();
  endtask : xfer
  initial begin
    void'($urandom(32'h9E048BC1));
    repeat (3) @(posedge clk);
    #5 rst = 0;
    strap = 1;
    step();
    chk({mx, mxoe}, 2'b01);
    strap = 0;
    step();
    chk({mx, mxoe}, 2'b00);
    xfer(0, 1, 20'hA0000, 8'h3C, 0);
    xfer(0, 0, 20'hDFFFF, 8'h00, 2);
    xfer(0, 0, 20'h9FFFF, 8'h00, 0);
    xfer(0, 1, 20'hE0000, 8'h11, 0);
    xfer(1, 1, 20'h0FC00, 8'h81, 1);
    xfer(1, 0, 20'h0F9FF, 8'h00, 0);
    xfer(1, 0, 20'h0FFEF, 8'h00, 3);
    xfer(1, 1, 20'h0FBFF, 8'h22, 0);
    xfer(1, 0, 20'h0FFF0, 8'h00, 0);
    repeat (40) xfer(1'($urandom), 1'($urandom), 20'($urandom),
                     8'($urandom), 2'($urandom));
    // bus must wait for the instruction boundary
    iend = 0;
    dma = 1;
    repeat (4) begin
      step();
      chk(ak, 1);
    end
    iend = 1;
    step();
    chk({ak, inw, hold}, 3'b011);
    a = 20'hB0000; io = 0; req = 1;
    repeat (3) begin
      step();
      chk({rdy, ak}, 2'b00);
    end
    // reset in mid-grant hands the bus back, then the request wins again
    rst = 1;
    step();
    chk({ak, inw, hold, rdy}, 4'b1000);
    rst = 0;
    step();
    chk({ak, inw, hold}, 3'b011);
    req = 0;
    dma = 0;
    step();
    chk({ak, inw, hold}, 3'b100);
    xfer(0, 0, 20'hC1234, 8'h00, 1);
    complete_run();
  end
endmodule : backplane_bus_interface_test
`default_nettype wire
